// File: design/burst_read_cfg.svh
`ifndef BURST_READ_CFG_SVH
`define BURST_READ_CFG_SVH
`define CFG_RESET_VALUE     16'h9CC4
`define CFG_MODE_BIT        15
`define CFG_SLEEP_BIT       14
`define CFG_LAT_MSB         13
`define CFG_LAT_LSB         10
`define CFG_HOLD_BIT        9
`define CFG_WAIT_BIT        8
`define CFG_ORDER_BIT       7
`define CFG_EDGE_BIT        6
`define CFG_RSV_MSB         5
`define CFG_RSV_LSB         3
`define CFG_LEN_MSB         2
`define CFG_LEN_LSB         0
`define CFG_LAT_BASE        4'h2
`define CFG_LEN_8B          3'h1
`define CFG_LEN_16B         3'h2
`define CFG_LEN_32B         3'h3
`define BEATS_8B            4'h2
`define BEATS_16B           4'h4
`define BEATS_32B           4'h8
`endif

// File: design/burst_read_pkg.sv
package burst_read_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_LATENCY = 3'h2,
    ST_DATA    = 3'h4
  } burst_state_e;

  typedef struct packed {
    logic        cmd_read;
    logic        cmd_write;
    logic        cmd_bank;
    logic [15:0] cmd_data;
  } cfg_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        bank;
    logic [31:0] array_data;
  } read_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } read_resp_s;

  typedef struct packed {
    logic [15:0]  cfg;
    logic [15:0]  cfg_pending;
    logic         pending;
    logic         show_bank;
    logic         show_active;
    burst_state_e state;
    logic [3:0]   count;
    logic [3:0]   beats_left;
    logic         adv_s1;
    logic         adv_s2;
    logic         adv_s3;
    logic         wait_ind;
    logic         burst_data;
    logic         sync_mode;
    logic         sleep_enable;
    read_resp_s   resp;
  } cfg_state_s;
endpackage : burst_read_pkg

// File: design/burst_read_config_register.sv
`include "burst_read_cfg.svh"
module burst_read_config_register (
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire burst_read_pkg::cfg_cmd_s  cmd,
  input  wire logic                      algorithm_busy,
  input  wire burst_read_pkg::read_req_s read_req,
  input  wire logic                      address_valid_n,
  output logic                           read_valid,
  output logic [31:0]                    read_data,
  output logic                           wait_indicator,
  output logic                           burst_data_phase,
  output logic                           sync_burst_mode,
  output logic                           sleep_enable,
  output logic [15:0]                    read_access_configuration
);
  import burst_read_pkg::*;

  cfg_state_s state_reg;
  cfg_state_s state_next;

  logic [3:0] lat_total;
  logic [3:0] burst_beats;
  logic       adv_start;
  logic       burst_on;
  logic [15:0] cfg_use;

  // Length code to beat count of 32-bit words
  always_comb begin
    burst_beats = 4'h0;
    unique case (state_reg.cfg[`CFG_LEN_MSB:`CFG_LEN_LSB])
      `CFG_LEN_8B:  burst_beats = `BEATS_8B;
      `CFG_LEN_16B: burst_beats = `BEATS_16B;
      `CFG_LEN_32B: burst_beats = `BEATS_32B;
      default:      burst_beats = 4'h0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cfg_use = state_reg.cfg;
    lat_total = state_reg.cfg[`CFG_LAT_MSB:`CFG_LAT_LSB] + `CFG_LAT_BASE;
    state_next.adv_s1 = ~address_valid_n;
    state_next.adv_s2 = state_reg.adv_s1;
    state_next.adv_s3 = state_reg.adv_s2;
    // start on active level or on release edge, whichever first
    adv_start = state_reg.adv_s2 | (state_reg.adv_s3 & ~state_reg.adv_s2);
    // burst only in sync mode with a valid length
    burst_on = ~state_reg.cfg[`CFG_MODE_BIT] && (burst_beats != 4'h0);
    state_next.resp.valid = 1'b0;

    // apply only between read accesses, never as a burst starts
    if (state_reg.pending && state_reg.state == ST_IDLE && !read_req.valid
        && !(adv_start && burst_on)) begin
      state_next.cfg = state_reg.cfg_pending;
      state_next.pending = 1'b0;
      cfg_use = state_reg.cfg_pending;
    end
    // write refused while busy; reached by command only
    // Taken after the apply so a write in the same cycle stays pending
    if (cmd.cmd_write && !algorithm_busy) begin
      state_next.cfg_pending = cmd.cmd_data;
      state_next.pending = 1'b1;
    end
    // read command accepted any time, bank captured
    if (cmd.cmd_read) begin
      state_next.show_bank = cmd.cmd_bank;
      state_next.show_active = 1'b1;
    end
    if (read_req.valid) begin
      state_next.resp.valid = 1'b1;
      // captured bank shows register with upper half zero
      if (state_reg.show_active && read_req.bank == state_reg.show_bank) begin
        state_next.resp.data = {16'h0000, state_reg.cfg};
      end else begin
        state_next.resp.data = read_req.array_data;
      end
    end

    case (state_reg.state)
      ST_IDLE: begin
        state_next.wait_ind = 1'b0;
        state_next.burst_data = 1'b0;
        if (adv_start && burst_on) begin
          state_next.state = ST_LATENCY;
          state_next.count = lat_total - 4'h1;
          state_next.beats_left = burst_beats;
          // wait during latency when bit 8 clear; shortest latency waits at once
          state_next.wait_ind = ~state_reg.cfg[`CFG_WAIT_BIT] | (lat_total <= 4'h2);
        end
      end
      ST_LATENCY: begin
        if (state_reg.count == 4'h1) begin
          state_next.wait_ind = 1'b0;
        end else if (state_reg.count == 4'h2) begin
          // wait stands in the cycle before data in both settings
          state_next.wait_ind = 1'b1;
        end
        if (state_reg.count <= 4'h1) begin
          state_next.state = ST_DATA;
          state_next.burst_data = 1'b1;
          state_next.wait_ind = 1'b0;
        end else begin
          state_next.count = state_reg.count - 4'h1;
        end
      end
      ST_DATA: begin
        // one word per rising clock, linear
        if (state_reg.beats_left <= 4'h1) begin
          state_next.state = ST_IDLE;
          state_next.burst_data = 1'b0;
        end else begin
          state_next.beats_left = state_reg.beats_left - 4'h1;
        end
      end
      default: begin
        state_next.state = ST_IDLE;
      end
    endcase

    state_next.sync_mode = ~cfg_use[`CFG_MODE_BIT];
    state_next.sleep_enable = ~cfg_use[`CFG_SLEEP_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // reset values, burst ended, asynchronous mode
      state_reg <= '{cfg: `CFG_RESET_VALUE, cfg_pending: `CFG_RESET_VALUE,
                     state: ST_IDLE, sleep_enable: 1'b1, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign read_valid = state_reg.resp.valid;
  assign read_data = state_reg.resp.data;
  assign wait_indicator = state_reg.wait_ind;
  assign burst_data_phase = state_reg.burst_data;
  assign sync_burst_mode = state_reg.sync_mode;
  assign sleep_enable = state_reg.sleep_enable;
  assign read_access_configuration = state_reg.cfg;

  // Assertions
  a_busy_write_dropped : assert property (@(posedge ref_clk) disable iff (reset)
    (cmd.cmd_write && algorithm_busy && !state_reg.pending) |=> !state_reg.pending)
    else $error("write accepted while busy");
  a_busy_cfg_kept : assert property (@(posedge ref_clk) disable iff (reset)
    (cmd.cmd_write && algorithm_busy && !state_reg.pending) |=> $stable(read_access_configuration))
    else $error("config changed by refused write");
  a_upper_half_zero : assert property (@(posedge ref_clk) disable iff (reset)
    (read_req.valid && state_reg.show_active && read_req.bank == state_reg.show_bank
     && !cmd.cmd_read) |=> (read_valid && read_data[31:16] == 16'h0000))
    else $error("register read upper half not zero");
  a_read_answered : assert property (@(posedge ref_clk) disable iff (reset)
    read_req.valid |=> read_valid)
    else $error("read not answered");
  a_other_bank_array : assert property (@(posedge ref_clk) disable iff (reset)
    (read_req.valid && read_req.bank != state_reg.show_bank)
    |=> read_data == $past(read_req.array_data))
    else $error("other bank did not return array data");
  a_bank_captured : assert property (@(posedge ref_clk) disable iff (reset)
    cmd.cmd_read |=> (state_reg.show_active && state_reg.show_bank == $past(cmd.cmd_bank)))
    else $error("bank not captured");
  a_reset_cfg_value : assert property (@(posedge ref_clk)
    reset |=> (read_access_configuration == `CFG_RESET_VALUE && !burst_data_phase))
    else $error("reset value wrong");
  a_reset_ends_burst : assert property (@(posedge ref_clk)
    reset |=> (state_reg.state == ST_IDLE && !wait_indicator && !sync_burst_mode))
    else $error("reset did not end burst");
  a_async_no_burst : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_IDLE && state_reg.cfg[`CFG_MODE_BIT])
    |=> state_reg.state == ST_IDLE)
    else $error("burst started in async mode");
  a_reserved_len_off : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_IDLE && (state_reg.cfg[`CFG_LEN_MSB:`CFG_LEN_LSB] == 3'h0
     || state_reg.cfg[`CFG_LEN_MSB]))
    |=> state_reg.state == ST_IDLE)
    else $error("burst started with disabled length");
  a_burst_words_end : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_DATA && state_reg.beats_left == 4'h1) |=> !burst_data_phase)
    else $error("burst ran past its length");
  a_sleep_follows_bit : assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (state_reg.state == ST_IDLE && !state_reg.pending)
    |-> sleep_enable == ~read_access_configuration[`CFG_SLEEP_BIT])
    else $error("sleep output mismatched");
  a_no_cfg_change_burst : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state != ST_IDLE) |=> $stable(read_access_configuration))
    else $error("config changed during burst");
  a_latency_then_data : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_IDLE && state_next.state == ST_LATENCY
     && state_reg.cfg[`CFG_LAT_MSB:`CFG_LAT_LSB] == 4'h1)
    |=> !burst_data_phase ##1 !burst_data_phase ##1 burst_data_phase)
    else $error("latency of three not honoured");
  a_wait_in_latency : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_LATENCY && !state_reg.cfg[`CFG_WAIT_BIT]) |-> wait_indicator)
    else $error("wait missing during latency");
  a_early_wait_single : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_LATENCY && state_reg.cfg[`CFG_WAIT_BIT] && state_reg.count > 4'h1)
    |-> !wait_indicator)
    else $error("early wait raised too soon");
  a_no_wait_idle : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_IDLE) |-> !wait_indicator)
    else $error("wait raised while idle");
  a_start_on_valid : assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg.state == ST_IDLE && state_reg.adv_s2 && burst_on)
    |=> state_reg.state == ST_LATENCY)
    else $error("burst not started");
endmodule : burst_read_config_register

// File: testbench/host_model.sv
module host_model (
  input  wire logic                      ref_clk,
  output burst_read_pkg::cfg_cmd_s       cmd,
  output burst_read_pkg::read_req_s      read_req,
  output logic                           address_valid_n,
  input  wire logic                      read_valid,
  input  wire logic [31:0]               read_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import burst_read_pkg::*;
  initial begin
    cmd = '0;
    read_req = '0;
    address_valid_n = 1'b1;
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic cfg_cmd(input logic wr, input logic bank, input logic [15:0] d);
    step();
    cmd = '{cmd_read: !wr, cmd_write: wr, cmd_bank: bank, cmd_data: d & 16'hFFC7};
    step();
    cmd = '{cmd_read: 1'b0, cmd_write: 1'b0, cmd_bank: !bank, cmd_data: ~d};
  endtask : cfg_cmd
  // Released lines carry inverted values
  task automatic rd(input logic bank, input logic [31:0] arr, output logic [31:0] q);
    int n;
    n = 0;
    step();
    read_req = '{valid: 1'b1, bank: bank, array_data: arr};
    step();
    read_req = '{valid: 1'b0, bank: !bank, array_data: ~arr};
    while (read_valid !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    q = (read_valid === 1'b1) ? read_data : 32'hDEAD0000;
  endtask : rd
  task automatic adv_pulse();
    step();
    address_valid_n = 1'b0;
    step();
    address_valid_n = 1'b1;
  endtask : adv_pulse
endmodule : host_model

// File: testbench/burst_read_config_register_tb_top.sv
module burst_read_config_register_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import burst_read_pkg::*;
  logic        ref_clk, reset, algorithm_busy, address_valid_n, read_valid;
  logic        wait_indicator, burst_data_phase, sync_burst_mode, sleep_enable, w;
  logic [31:0] read_data, q;
  logic [15:0] read_access_configuration;
  cfg_cmd_s    cmd;
  read_req_s   read_req;
  int          error_cnt, num_checks, lat, lat0, n, wn;
  logic [15:0] tbl [7] = '{16'h04C1, 16'h04C2, 16'h04C3, 16'h14C1, 16'h04C4, 16'h84C3,
                           16'h05C1};
  int          beats [7] = '{2, 4, 8, 2, 0, 0, 2};
  // Wait samples: whole latency when bit 8 clear, one cycle when set
  int          wexp [7] = '{2, 2, 2, 6, 0, 0, 1};
  host_model h (.ref_clk(ref_clk), .cmd(cmd), .read_req(read_req),
    .address_valid_n(address_valid_n), .read_valid(read_valid), .read_data(read_data));
  burst_read_config_register u_dut (.ref_clk(ref_clk), .reset(reset), .cmd(cmd),
    .algorithm_busy(algorithm_busy), .read_req(read_req), .address_valid_n(address_valid_n),
    .read_valid(read_valid), .read_data(read_data), .wait_indicator(wait_indicator),
    .burst_data_phase(burst_data_phase), .sync_burst_mode(sync_burst_mode),
    .sleep_enable(sleep_enable), .read_access_configuration(read_access_configuration));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic burst();
    lat = 0;
    n = 0;
    w = 1'b0;
    wn = 0;
    h.adv_pulse();
    while (burst_data_phase !== 1'b1 && lat < 40) begin
      w |= wait_indicator;
      wn += (wait_indicator === 1'b1);
      h.step();
      lat++;
    end
    while (burst_data_phase === 1'b1 && n < 20) begin
      h.step();
      n++;
    end
  endtask : burst
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    algorithm_busy = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 reset = 1'b0;
    check(read_access_configuration, 32'h9CC4);
    check(sleep_enable, 1);
    check(sync_burst_mode, 0);
    h.rd(1'b0, 32'hA5A50001, q);
    check(q, 32'hA5A50001);
    for (int b = 0; b < 2; b++) begin
      h.cfg_cmd(1'b0, b[0], 16'h0);
      h.rd(b[0], 32'h5A5A0002, q);
      check(q, 32'h00009CC4);
      h.rd(!b[0], 32'h5A5A0003, q);
      check(q, 32'h5A5A0003);
    end
    $display("test register read done");
    algorithm_busy = 1'b1;
    h.cfg_cmd(1'b1, 1'b0, 16'h04C1);
    repeat (3) h.step();
    h.rd(1'b1, 32'h12340004, q);
    check(q, 32'h00009CC4);
    algorithm_busy = 1'b0;
    $display("test busy write done");
    for (int i = 0; i < 7; i++) begin
      h.cfg_cmd(1'b1, 1'b0, tbl[i]);
      repeat (3) h.step();
      check(read_access_configuration, tbl[i]);
      check(sync_burst_mode, !tbl[i][15]);
      burst();
      check(n, beats[i]);
      check(w, beats[i] > 0);
      if (i == 0) lat0 = lat;
      if (i == 3) check(lat - lat0, 4);
      check(wn, wexp[i]);
      if (i == 6) check(lat, lat0);
    end
    $display("test burst done");
    h.cfg_cmd(1'b1, 1'b0, 16'h04C3);
    repeat (3) h.step();
    h.adv_pulse();
    n = 0;
    while (burst_data_phase !== 1'b1 && n < 40) begin
      h.step();
      n++;
    end
    reset = 1'b1;
    h.step();
    reset = 1'b0;
    check(burst_data_phase, 0);
    check(sync_burst_mode, 0);
    check(read_access_configuration, 32'h9CC4);
    $display("test reset in burst done");
    test_done();
  end
endmodule : burst_read_config_register_tb_top
